// >>> emw_core.v
// emw_core.v: drive-side handling of the extended multi-sector write
// commands (plain and forced-unit-access) behind the taskfile registers.
// assumes: host strobes are synchronous to CORE_CLK_I; media port is on-chip
// logic on the same clock; block size comes from a separate set-multiple unit.
//
// Contract
// - opcode 39h starts extended multiple write
// - opcode CEh starts forced-unit-access variant
// - accept host sectors, then commit to media
// - combined count zero means 65536 sectors
// - assemble 48-bit address from current/previous slots
// - report failing address, HOB selects byte half
// - one interrupt per multiple block
// - data moves as 16-bit words
// - forced variant: media done before ending status
// - uncorrectable error stops at failing sector
`default_nettype none
`include "emw_regs.vh"
module emw_core (
    input  wire        CORE_CLK_I,
    input  wire        RESETN_I,
    input  wire        CE_I,
    input  wire        TF_WR_I,       // host register write strobe
    input  wire        TF_RD_I,       // host register read strobe
    input  wire [2:0]  TF_ADDR_I,
    input  wire [15:0] TF_WDATA_I,
    input  wire        HOB_I,         // high-order byte select
    input  wire [7:0]  BLK_SIZE_I,    // sectors per block, 0 treated as 1
    input  wire        WCACHE_EN_I,   // write cache enabled
    input  wire        MEDIA_DONE_I,  // sector committed, one-cycle pulse
    input  wire        MEDIA_UNC_I,   // uncorrectable error on that sector
    input  wire        MEDIA_IDNF_I,  // sector not found
    output reg  [15:0] TF_RDATA_O,
    output reg         INTRQ_O,
    output reg         MEDIA_WR_O,    // one-cycle pulse, word to media
    output reg  [15:0] MEDIA_WDATA_O,
    output reg  [47:0] MEDIA_LBA_O,
    output reg         MEDIA_FLUSH_O  // level: forced commit in progress
);
    localparam ST_IDLE = 2'h0;
    localparam ST_XFER = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg [1:0]  state_q;
    reg [7:0]  scnt_cur_q;
    reg [7:0]  scnt_prv_q;
    reg [7:0]  snum_cur_q;
    reg [7:0]  snum_prv_q;
    reg [7:0]  cyll_cur_q;
    reg [7:0]  cyll_prv_q;
    reg [7:0]  cylh_cur_q;
    reg [7:0]  cylh_prv_q;
    reg [7:0]  status_q;
    reg [7:0]  error_q;
    reg [16:0] remain_q;      // sectors left to receive
    reg [16:0] pending_q;     // sectors sent to media, not yet committed
    reg [8:0]  word_q;        // words left in current sector
    reg [7:0]  blk_q;         // sectors left in current block
    reg        fua_q;
    reg [47:0] lba_q;         // next sector address for the host stream
    reg [47:0] fail_q;        // address of first unrecoverable sector
    // media commits in order, so the next pulse always belongs to this
    // address; the host stream runs ahead and cannot name the failure
    reg [47:0] commit_q;      // address of the next sector to be committed

    wire [16:0] req_cnt = {scnt_prv_q, scnt_cur_q} == 16'h0000 ? 17'h10000
                          : {1'b0, scnt_prv_q, scnt_cur_q};
    wire [7:0]  blk_sz  = (BLK_SIZE_I == 8'h00) ? 8'h01 : BLK_SIZE_I;
    wire        cmd_wr  = TF_WR_I && TF_ADDR_I == `EMW_A_CMD && state_q == ST_IDLE;
    wire        data_wr = TF_WR_I && TF_ADDR_I == `EMW_A_DATA && state_q == ST_XFER;
    wire        sec_end = data_wr && word_q == 9'h001;
    wire        fail    = MEDIA_DONE_I && (MEDIA_UNC_I || MEDIA_IDNF_I);

    // parameter registers: each write while idle pushes current into previous slot
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            scnt_cur_q <= 8'h00;
            scnt_prv_q <= 8'h00;
            snum_cur_q <= 8'h00;
            snum_prv_q <= 8'h00;
            cyll_cur_q <= 8'h00;
            cyll_prv_q <= 8'h00;
            cylh_cur_q <= 8'h00;
            cylh_prv_q <= 8'h00;
        end else if (CE_I && TF_WR_I && state_q == ST_IDLE) begin
            case (TF_ADDR_I)
                `EMW_A_SCNT: begin
                    scnt_prv_q <= scnt_cur_q;
                    scnt_cur_q <= TF_WDATA_I[7:0];
                end
                `EMW_A_SNUM: begin
                    snum_prv_q <= snum_cur_q;
                    snum_cur_q <= TF_WDATA_I[7:0];
                end
                `EMW_A_CYLL: begin
                    cyll_prv_q <= cyll_cur_q;
                    cyll_cur_q <= TF_WDATA_I[7:0];
                end
                `EMW_A_CYLH: begin
                    cylh_prv_q <= cylh_cur_q;
                    cylh_cur_q <= TF_WDATA_I[7:0];
                end
                default: ;
            endcase
        end
    end

    // command sequencer; media errors win over a same-cycle host word
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_q       <= ST_IDLE;
            status_q      <= `EMW_STATUS_RST;
            error_q       <= `EMW_ERROR_RST;
            remain_q      <= 17'h00000;
            pending_q     <= 17'h00000;
            word_q        <= 9'h000;
            blk_q         <= 8'h00;
            fua_q         <= 1'b0;
            lba_q         <= 48'h0;
            fail_q        <= 48'h0;
            commit_q      <= 48'h0;
            INTRQ_O       <= 1'b0;
            MEDIA_WR_O    <= 1'b0;
            MEDIA_WDATA_O <= 16'h0000;
            MEDIA_LBA_O   <= 48'h0;
            MEDIA_FLUSH_O <= 1'b0;
        end else if (CE_I) begin
            MEDIA_WR_O <= 1'b0;
            // reading status acknowledges the interrupt
            if (TF_RD_I && TF_ADDR_I == `EMW_A_CMD)
                INTRQ_O <= 1'b0;
            if (TF_WR_I && TF_ADDR_I == `EMW_A_CMD && state_q == ST_IDLE) begin
                error_q <= 8'h00;
                if (TF_WDATA_I[7:0] == `EMW_OP_WRMULT_EXT || TF_WDATA_I[7:0] == `EMW_OP_WRMULT_FUA) begin
                    fua_q     <= (TF_WDATA_I[7:0] == `EMW_OP_WRMULT_FUA);
                    lba_q     <= {cylh_prv_q, cyll_prv_q, snum_prv_q,
                                  cylh_cur_q, cyll_cur_q, snum_cur_q};
                    commit_q  <= {cylh_prv_q, cyll_prv_q, snum_prv_q,
                                  cylh_cur_q, cyll_cur_q, snum_cur_q};
                    remain_q  <= req_cnt;
                    pending_q <= 17'h00000;
                    word_q    <= `EMW_WORDS_PER_SEC;
                    blk_q     <= blk_sz;
                    state_q   <= ST_XFER;
                    status_q  <= 8'h58;   // busy clear, data request set
                end else begin
                    error_q  <= 8'h04;   // unknown opcode: abort
                    status_q <= 8'h51;
                    INTRQ_O  <= 1'b1;
                end
            end
            case (state_q)
                ST_XFER, ST_WAIT: begin
                    if (fail) begin
                        // stop at the failing sector, nothing more accepted
                        fail_q        <= commit_q;
                        error_q       <= MEDIA_IDNF_I ? 8'h10 : 8'h04;
                        status_q      <= 8'h51;
                        INTRQ_O       <= 1'b1;
                        MEDIA_FLUSH_O <= 1'b0;
                        state_q       <= ST_IDLE;
                    end else begin
                        // a stray pulse left from an earlier command would skew this
                        if (MEDIA_DONE_I)
                            commit_q <= commit_q + 48'h1;
                        if (data_wr) begin
                            MEDIA_WR_O    <= 1'b1;
                            MEDIA_WDATA_O <= TF_WDATA_I;
                            MEDIA_LBA_O   <= lba_q;
                            word_q        <= sec_end ? `EMW_WORDS_PER_SEC : word_q - 9'h001;
                        end
                        if (sec_end) begin
                            lba_q    <= lba_q + 48'h1;
                            remain_q <= remain_q - 17'h00001;
                            blk_q    <= (blk_q == 8'h01) ? blk_sz : blk_q - 8'h01;
                            if (remain_q == 17'h00001) begin
                                state_q       <= ST_WAIT;
                                status_q      <= 8'h90;   // busy while media commits
                                MEDIA_FLUSH_O <= fua_q;
                            end else if (blk_q == 8'h01) begin
                                INTRQ_O <= 1'b1;          // block boundary
                            end
                        end
                        // cache off or forced access: wait for every commit
                        if (sec_end && !MEDIA_DONE_I)
                            pending_q <= pending_q + 17'h00001;
                        else if (MEDIA_DONE_I && !sec_end && pending_q != 17'h00000)
                            pending_q <= pending_q - 17'h00001;
                        if (state_q == ST_WAIT &&
                            ((WCACHE_EN_I && !fua_q) || pending_q == 17'h00000 ||
                             (pending_q == 17'h00001 && MEDIA_DONE_I))) begin
                            status_q      <= 8'h50;
                            INTRQ_O       <= 1'b1;
                            MEDIA_FLUSH_O <= 1'b0;
                            state_q       <= ST_IDLE;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // read mux; address bytes come from the failure record
    always @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I)
            TF_RDATA_O <= 16'h0000;
        else if (CE_I) begin
            case (TF_ADDR_I)
                `EMW_A_ERR:  TF_RDATA_O <= {8'h00, error_q};
                `EMW_A_SCNT: TF_RDATA_O <= 16'h0000;
                `EMW_A_SNUM: TF_RDATA_O <= {8'h00, HOB_I ? fail_q[31:24] : fail_q[7:0]};
                `EMW_A_CYLL: TF_RDATA_O <= {8'h00, HOB_I ? fail_q[39:32] : fail_q[15:8]};
                `EMW_A_CYLH: TF_RDATA_O <= {8'h00, HOB_I ? fail_q[47:40] : fail_q[23:16]};
                `EMW_A_CMD:  TF_RDATA_O <= {8'h00, status_q};
                default:     TF_RDATA_O <= 16'h0000;
            endcase
        end
    end
endmodule // emw_core
`default_nettype wire

// >>> emw_regs.vh
// emw_regs.vh: constants of the extended multi-sector write interpreter
// assumes inclusion by emw_core.v only; plain Verilog-2005
`ifndef EMW_REGS_VH
`define EMW_REGS_VH
// taskfile register addresses (3-bit command block select)
`define EMW_A_DATA    3'h0
`define EMW_A_ERR     3'h1
`define EMW_A_SCNT    3'h2
`define EMW_A_SNUM    3'h3
`define EMW_A_CYLL    3'h4
`define EMW_A_CYLH    3'h5
`define EMW_A_DEV     3'h6
`define EMW_A_CMD     3'h7
// command opcodes
`define EMW_OP_WRMULT_EXT 8'h39
`define EMW_OP_WRMULT_FUA 8'hce
// status bit positions
`define EMW_ST_BSY 7
`define EMW_ST_RDY 6
`define EMW_ST_DF  5
`define EMW_ST_DSC 4
`define EMW_ST_DRQ 3
`define EMW_ST_ERR 0
// error bit positions
`define EMW_ER_IDN 4
`define EMW_ER_ABT 2
// reset values
`define EMW_STATUS_RST 8'h50
`define EMW_ERROR_RST  8'h00
// words per 512-byte sector
`define EMW_WORDS_PER_SEC 9'h100
`endif

// >>> emw_core_assertions.sv
// emw_core_assertions.sv: port checker for emw_core
// assumes each command starts on a sector boundary
`default_nettype none
module emw_chk (
    input wire logic        CORE_CLK_I,
    input wire logic        RESETN_I,
    input wire logic        TF_WR_I,
    input wire logic        TF_RD_I,
    input wire logic [2:0]  TF_ADDR_I,
    input wire logic [15:0] TF_WDATA_I,
    input wire logic        MEDIA_DONE_I,
    input wire logic        MEDIA_UNC_I,
    input wire logic        MEDIA_IDNF_I,
    input wire logic        INTRQ_O,
    input wire logic        MEDIA_WR_O,
    input wire logic [15:0] MEDIA_WDATA_O,
    input wire logic [47:0] MEDIA_LBA_O,
    input wire logic        MEDIA_FLUSH_O
);
    timeunit 1ns; timeprecision 1ps;
    logic [7:0]  wcnt_q;
    logic [47:0] lba_q;
    // word slot in the sector, and the address of its first word
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wcnt_q <= 8'h00;
            lba_q  <= 48'h0;
        end else if (MEDIA_DONE_I && (MEDIA_UNC_I || MEDIA_IDNF_I)) begin
            wcnt_q <= 8'h00;   // a failure cuts the sector short
        end else if (MEDIA_WR_O) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q == 8'h00) lba_q <= MEDIA_LBA_O;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_fail; MEDIA_DONE_I && (MEDIA_UNC_I || MEDIA_IDNF_I); endsequence
    sequence s_stat_rd; TF_RD_I && TF_ADDR_I == 3'h7; endsequence
    a_word_to_media: assert property (MEDIA_WR_O |->
        $past(TF_WR_I && TF_ADDR_I == 3'h0) && MEDIA_WDATA_O == $past(TF_WDATA_I)) else $error("bad media word");
    a_lba_hold: assert property (MEDIA_WR_O && wcnt_q != 8'h00 |-> MEDIA_LBA_O == lba_q)
        else $error("address moved in sector");
    a_irq_clear: assert property (s_stat_rd |=> !INTRQ_O) else $error("irq kept after status read");
    a_irq_hold: assert property (INTRQ_O && !(TF_RD_I && TF_ADDR_I == 3'h7) |=> INTRQ_O)
        else $error("irq dropped");
    a_irq_at_block: assert property ($rose(INTRQ_O) |-> wcnt_q == 8'h00 || wcnt_q == 8'hff)
        else $error("irq mid sector");
    a_fua_end_wait: assert property (MEDIA_FLUSH_O && !MEDIA_DONE_I |=> !$rose(INTRQ_O))
        else $error("ending before commit");
    a_fua_no_word: assert property (MEDIA_FLUSH_O && $past(MEDIA_FLUSH_O) |-> !MEDIA_WR_O)
        else $error("word during flush");
    a_err_stops: assert property (s_fail |-> ##2 !MEDIA_WR_O [*8]) else $error("write after failure");
endmodule // emw_chk
bind emw_core emw_chk u_emw_chk (.CORE_CLK_I, .RESETN_I, .TF_WR_I, .TF_RD_I, .TF_ADDR_I, .TF_WDATA_I,
    .MEDIA_DONE_I, .MEDIA_UNC_I, .MEDIA_IDNF_I, .INTRQ_O, .MEDIA_WR_O, .MEDIA_WDATA_O, .MEDIA_LBA_O, .MEDIA_FLUSH_O);
`default_nettype wire

// >>> emw_host.sv
// emw_host.sv: host controller model on the taskfile register port
// assumes tasks are called one at a time from the bench
`default_nettype none
module emw_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output var  logic        wr_o = 1'b0,
    output var  logic        rd_o = 1'b0,
    output var  logic [2:0]  addr_o = 3'h0,
    output var  logic [15:0] wdata_o = 16'h0
);
    timeunit 1ns; timeprecision 1ps;
    // released data is inverted so a stale word cannot pass as fresh
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_i) {wr_o, addr_o, wdata_o} <= {1'b1, a, v};
        @(posedge clk_i) {wr_o, wdata_o} <= {1'b0, ~v};
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk_i) {rd_o, addr_o} <= {1'b1, a};
        @(posedge clk_i) rd_o <= 1'b0;
        @(posedge clk_i) v = rdata_i;
    endtask
    // previous slot before current, command last
    task automatic setup(input logic [15:0] n, input logic [47:0] l, input logic [7:0] op);
        logic [7:0] v [9];
        v = '{n[15:8], n[7:0], l[31:24], l[7:0], l[39:32], l[15:8], l[47:40], l[23:16], op};
        for (int i = 0; i < 9; i++) wr(i == 8 ? 3'h7 : 3'(i / 2 + 2), {8'h00, v[i]});
    endtask
endmodule // emw_host
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for emw_core
// assumes emw_host drives the register port; media answers here
`default_nettype none
module tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic clk = 0, rstn = 0, hob = 0, cache = 0, done = 0, unc = 0, idnf = 0, wr, rd, irq, mwr, fl;
    logic [2:0] ad; logic [1:0] fail = 0; logic [5:0] dly = 0; logic [7:0] blk = 1, mw = 0;
    logic [15:0] wd, rdat, md, d; logic [47:0] lba, last; int miscompares = 0, n_tests = 0, nwr, ndone;
    localparam logic [47:0] L = 48'h0a1b2c3d4e5f;
    always #2.5 clk = ~clk;
    emw_core u_emw_core (.CORE_CLK_I(clk), .RESETN_I(rstn), .CE_I(1'b1), .TF_WR_I(wr), .TF_RD_I(rd),
        .TF_ADDR_I(ad), .TF_WDATA_I(wd), .HOB_I(hob), .BLK_SIZE_I(blk), .WCACHE_EN_I(cache), .MEDIA_DONE_I(done),
        .MEDIA_UNC_I(unc), .MEDIA_IDNF_I(idnf), .TF_RDATA_O(rdat), .INTRQ_O(irq), .MEDIA_WR_O(mwr),
        .MEDIA_WDATA_O(md), .MEDIA_LBA_O(lba), .MEDIA_FLUSH_O(fl));
    emw_host u_host (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd));
    // media commits a sector 20 cycles after its last word; slow on purpose
    always @(posedge clk) begin
        {done, unc, idnf} <= {dly == 6'h01, {2{dly == 6'h01}} & fail};
        if (dly != 6'h00) dly <= dly - 6'h01;
        if (done) ndone++;
        if (mwr) begin
            {mw, last} <= {mw + 8'h01, lba};
            nwr++;
            if (mw == 8'hff) dly <= 6'h14;
        end
        if (done && (unc || idnf)) mw <= 8'h00;
    end
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic st(input logic [2:0] a, input logic [15:0] e);
        u_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic sector;
        for (int i = 0; i < 256; i++) u_host.wr(3'h0, 16'(i) ^ 16'h5a00);
    endtask
    task automatic wirq;
        for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk);
        chk(irq, 1'b1);
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic t_write(input logic [7:0] op, input logic c, input logic [7:0] b);
        repeat (32) @(posedge clk);
        cache <= c;
        blk <= b;
        nwr = 0;
        ndone = 0;
        u_host.setup(16'h0002, L, op);
        st(3'h7, 16'h0058);
        sector;
        if (b == 8'h01) wirq;
        st(3'h7, 16'h0058);
        sector;
        wirq;
        if (op == 8'hce || !c) chk(ndone, 2);
        chk(nwr, 512);
        chk(last, L + 1);
        st(3'h7, 16'h0050);
        $display("write %h done", op);
    endtask
    task automatic t_err(input logic [1:0] f);
        fail <= f;
        cache <= 1'b0;
        blk <= 8'h01;
        u_host.setup(16'h0002, L, 8'h39);
        for (int s = 0; s < 2; s++) begin
            sector;
            wirq;
            if (s == 0) st(3'h7, 16'h0058);
        end
        st(3'h7, 16'h0051);
        st(3'h1, f[0] ? 16'h0010 : 16'h0004);
        for (int i = 0; i < 6; i++) begin
            hob <= i > 2;
            u_host.rd(3'(i % 3 + 3), d);
            chk(d[7:0], (L >> (8 * (i % 3) + 24 * (i / 3))) & 48'hff);
        end
        fail <= 2'b00;
        hob <= 1'b0;
        $display("error %b done", f);
    endtask
    task automatic t_zero;
        u_host.setup(16'h0000, L, 8'h34);
        wirq;
        st(3'h7, 16'h0051);
        cache <= 1'b1;
        blk <= 8'h01;
        u_host.setup(16'h0000, L, 8'h39);
        for (int s = 0; s < 2; s++) begin
            sector;
            wirq;
            st(3'h7, 16'h0058);
        end
        do_reset;
        st(3'h7, 16'h0050);
        $display("zero count done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        do_reset;
        t_write(8'h39, 1'b1, 8'h01);
        t_write(8'hce, 1'b1, 8'h02);
        t_write(8'h39, 1'b0, 8'h01);
        t_err(2'b01);
        t_err(2'b10);
        t_zero;
        tally_and_finish;
    end
    // watchdog: the tests need about 33 us
    initial begin
        #150us miscompares++;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
